// ---- src/ccpu_pkg.sv ----
// Notes on behaviour
// [R1] Each capture event copies the 16-bit first timer count into the value pair.
// [R2] Capture event: every falling, rising, 4th rising or 16th rising edge.
// [R3] Capture codes: 0100 falling, 0101 rising, 0110 fourth, 0111 sixteenth rising.
// [R4] Every capture sets the irq flag; only software clears it.
// [R5] A newer capture overwrites an unread one, with no loss record.
// [R6] First timer must run synchronously; asynchronous counting is not supported.
// [R7] Mode changes may raise a spurious capture flag; software masks and clears it.
// [R8] Capture prescaler clears when off, outside capture modes, and on reset.
// [R9] Switching between capture prescalers keeps the prescaler count.
// [R10] Compare mode matches value pair against first timer and acts per mode.
// [R11] Compare codes 1000 drive pin high, 1001 drive low; both set flag.
// [R12] Every compare match sets the irq flag.
// [R13] Writing zero to the control register forces the pin latch low.
// [R14] Code 1010 only raises the flag; the pin is left alone.
// [R15] Code 1011 resets first timer and starts a conversion if enabled.
// [R16] Trigger fires on match; timer zeroes at its next clock tick.
// [R17] Trigger-caused timer reset must not set the first timer overflow flag.
// [R18] Removing the match before the timer tick cancels the timer reset.
// [R19] PWM boundary clears period timer, sets pin unless duty zero, loads duty.
// [R20] PWM period is (limit+1) times 4 clocks times period timer prescale.
// [R21] Duty is low value register plus control bits 5:4, applied at boundary.
// [R22] Control bits 7:6 read zero, 5:4 duty low bits, 3:0 mode.
// [R23] In PWM mode the high value register is read-only, holding active duty.
// [R24] Time base is period timer plus two prescaler or clock phase bits.
// [R25] Time base equal to buffered duty drives the pin low for the period.
// [R26] The pin is synchronised before edge detection.
package ccpu_pkg;
  // Register offsets
  localparam logic [2:0] OFS_CTRL   = 3'h0;
  localparam logic [2:0] OFS_CVL    = 3'h1;
  localparam logic [2:0] OFS_CVH    = 3'h2;
  localparam logic [2:0] OFS_PER    = 3'h3;
  localparam logic [2:0] OFS_T2C    = 3'h4;
  localparam logic [2:0] OFS_STAT   = 3'h5;
  localparam logic [2:0] OFS_T2     = 3'h6;
  // Mode codes
  localparam logic [3:0] MODE_OFF   = 4'h0;
  localparam logic [3:0] MODE_CAPF  = 4'h4;
  localparam logic [3:0] MODE_CAPR  = 4'h5;
  localparam logic [3:0] MODE_CAP4  = 4'h6;
  localparam logic [3:0] MODE_CAP16 = 4'h7;
  localparam logic [3:0] MODE_CSET  = 4'h8;
  localparam logic [3:0] MODE_CCLR  = 4'h9;
  localparam logic [3:0] MODE_CSWI  = 4'hA;
  localparam logic [3:0] MODE_CSEV  = 4'hB;
  // Field positions
  localparam int T2C_ON_BIT = 2;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_IE_BIT = 1;
  // Reset values
  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [7:0] RST_PER  = 8'hFF;
  localparam logic [2:0] RST_T2C  = 3'h0;
  // Clocks per period timer increment at prescale 1:1
  localparam int CLK_PER_INC = 4;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccpu_bus_t;
endpackage

// ---- src/ccpu_top.sv ----
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module ccpu_top (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Register port
  input  wire ccpu_pkg::ccpu_bus_t bus,
  output logic [7:0]             rdata_r,
  // First timer side
  input  wire logic [15:0]       first_timer_count,
  input  wire logic              first_timer_tick,
  input  wire logic              adc_enable,
  output logic                   first_timer_clear_r,
  output logic                   adc_start_r,
  // Pin
  input  wire logic              unit_pin_in,
  output logic                   unit_pin_out_r,
  output logic                   unit_pin_oe_r,
  // Flags
  output logic                   unit_irq_flag_r,
  output logic                   irq_out_r
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic is_cap(input logic [3:0] m);
    return m[3:2] == 2'b01;
  endfunction

  function automatic logic is_cmp(input logic [3:0] m);
    return m[3:2] == 2'b10;
  endfunction

  function automatic logic is_pwm(input logic [3:0] m);
    return m[3:2] == 2'b11;
  endfunction

  function automatic logic wr_at(input ccpu_pkg::ccpu_bus_t b, input logic [2:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [5:0]  ctrl_r;
  logic [7:0]  cvl_r;
  logic [7:0]  cvh_r;
  logic [7:0]  per_r;
  logic [2:0]  t2c_r;
  logic        ie_r;
  logic [7:0]  t2_r;
  logic [5:0]  pre_r;
  logic [1:0]  lat2_r;
  logic [3:0]  psc_r;
  logic        pin_s1_r;
  logic        pin_s2_r;
  logic        pin_s3_r;
  logic        match_d_r;
  logic        pin_r;
  logic        boundary_d_r;

  logic [3:0]  mode;
  logic [1:0]  dc;
  logic        rise;
  logic        fall;
  logic        cap_evt;
  logic        cmp_match;
  logic        cmp_fire;
  logic [5:0]  pre_lim;
  logic        t2_inc;
  logic        boundary;
  logic [1:0]  low2;
  logic [9:0]  tbase;
  logic        flag_clr;

  assign mode = ctrl_r[3:0];
  assign dc   = ctrl_r[5:4];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r <= ccpu_pkg::RST_CTRL;
    end else if (wr_at(bus, ccpu_pkg::OFS_CTRL)) begin
      ctrl_r <= bus.wdata[5:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      per_r <= ccpu_pkg::RST_PER;
      t2c_r <= ccpu_pkg::RST_T2C;
      ie_r  <= 1'b0;
    end else begin
      if (wr_at(bus, ccpu_pkg::OFS_PER)) begin
        per_r <= bus.wdata;
      end
      if (wr_at(bus, ccpu_pkg::OFS_T2C)) begin
        t2c_r <= bus.wdata[2:0];
      end
      if (wr_at(bus, ccpu_pkg::OFS_STAT)) begin
        ie_r <= bus.wdata[ccpu_pkg::STAT_IE_BIT];
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst || !bus.rd) begin
      rdata_r <= 8'h00;
    end else begin
      case (bus.addr)
        ccpu_pkg::OFS_CTRL: rdata_r <= {2'b00, ctrl_r}; // [R22]
        ccpu_pkg::OFS_CVL:  rdata_r <= cvl_r;
        ccpu_pkg::OFS_CVH:  rdata_r <= cvh_r;
        ccpu_pkg::OFS_PER:  rdata_r <= per_r;
        ccpu_pkg::OFS_T2C:  rdata_r <= {5'h00, t2c_r};
        ccpu_pkg::OFS_STAT: rdata_r <= {6'h00, ie_r, unit_irq_flag_r};
        ccpu_pkg::OFS_T2:   rdata_r <= t2_r;
        default:            rdata_r <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin synchroniser and capture
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= unit_pin_in; // [R26]
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign rise = pin_s2_r && !pin_s3_r;
  assign fall = !pin_s2_r && pin_s3_r;

  // Free-running count of rising edges; the 4th and 16th taps share it
  always_ff @(posedge ref_clk) begin
    if (srst || !is_cap(mode)) begin
      psc_r <= 4'h0; // [R8]
    end else if (rise) begin
      psc_r <= psc_r + 4'h1; // [R9]
    end
  end

  always_comb begin
    case (mode)
      ccpu_pkg::MODE_CAPF:  cap_evt = fall; // [R2] [R3]
      ccpu_pkg::MODE_CAPR:  cap_evt = rise;
      ccpu_pkg::MODE_CAP4:  cap_evt = rise && (psc_r[1:0] == 2'h3);
      ccpu_pkg::MODE_CAP16: cap_evt = rise && (psc_r == 4'hF);
      default:              cap_evt = 1'b0;
    endcase
  end

  // Capture beats a same-cycle software write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cvl_r <= 8'h00;
    end else if (cap_evt) begin
      cvl_r <= first_timer_count[7:0]; // [R1] [R5]
    end else if (wr_at(bus, ccpu_pkg::OFS_CVL)) begin
      cvl_r <= bus.wdata; // [R21]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cvh_r  <= 8'h00;
      lat2_r <= 2'h0;
    end else if (cap_evt) begin
      cvh_r <= first_timer_count[15:8]; // [R1] [R5]
    end else if (is_pwm(mode)) begin
      if (boundary) begin
        cvh_r  <= cvl_r; // [R19] [R21]
        lat2_r <= dc;
      end
    end else if (wr_at(bus, ccpu_pkg::OFS_CVH)) begin
      cvh_r <= bus.wdata; // [R23]
    end
  end

  // ------------------------------------------------------------
  // Compare
  // ------------------------------------------------------------
  // Counter is assumed synchronous to ref_clk
  assign cmp_match = first_timer_count == {cvh_r, cvl_r}; // [R6] [R10]
  assign cmp_fire  = is_cmp(mode) && cmp_match && !match_d_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      match_d_r <= 1'b0;
    end else begin
      match_d_r <= cmp_match;
    end
  end

  // Timer owner zeroes its count on the next tick while this is high,
  // without raising its overflow flag
  always_ff @(posedge ref_clk) begin
    if (srst || mode != ccpu_pkg::MODE_CSEV || !cmp_match) begin
      first_timer_clear_r <= 1'b0; // [R18]
    end else if (cmp_fire) begin
      first_timer_clear_r <= 1'b1; // [R15] [R16] [R17]
    end else if (first_timer_tick) begin
      first_timer_clear_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      adc_start_r <= 1'b0;
    end else begin
      adc_start_r <= cmp_fire && (mode == ccpu_pkg::MODE_CSEV) && adc_enable; // [R15]
    end
  end

  // ------------------------------------------------------------
  // Period timer and PWM
  // ------------------------------------------------------------
  always_comb begin
    case (t2c_r[1:0])
      2'b00:   pre_lim = 6'(ccpu_pkg::CLK_PER_INC - 1);
      2'b01:   pre_lim = 6'(ccpu_pkg::CLK_PER_INC * 4 - 1);
      default: pre_lim = 6'(ccpu_pkg::CLK_PER_INC * 16 - 1);
    endcase
  end

  always_comb begin
    case (t2c_r[1:0])
      2'b00:   low2 = pre_r[1:0]; // [R24]
      2'b01:   low2 = pre_r[3:2];
      default: low2 = pre_r[5:4];
    endcase
  end

  assign t2_inc   = t2c_r[ccpu_pkg::T2C_ON_BIT] && (pre_r >= pre_lim);
  assign boundary = t2_inc && (t2_r == per_r);
  assign tbase    = {t2_r, low2};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pre_r <= 6'h00;
    end else if (t2_inc) begin
      pre_r <= 6'h00; // [R20]
    end else if (t2c_r[ccpu_pkg::T2C_ON_BIT]) begin
      pre_r <= pre_r + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      t2_r <= 8'h00;
    end else if (boundary) begin
      t2_r <= 8'h00; // [R19] [R20]
    end else if (t2_inc) begin
      t2_r <= t2_r + 8'h01;
    end
  end

  // The pin latch acts on the time base one clock late, so the period start
  // waits a clock as well; otherwise the high time is one clock too long
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      boundary_d_r <= 1'b0;
    end else begin
      boundary_d_r <= is_pwm(mode) && boundary; // [R19]
    end
  end

  // ------------------------------------------------------------
  // Pin latch, shared by compare and PWM
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || (wr_at(bus, ccpu_pkg::OFS_CTRL) && bus.wdata == 8'h00)) begin
      pin_r <= 1'b0; // [R13]
    end else if (is_pwm(mode)) begin
      if (boundary_d_r) begin
        pin_r <= {cvh_r, lat2_r} != 10'h000; // [R19]
      end else if (tbase == {cvh_r, lat2_r}) begin
        pin_r <= 1'b0; // [R25]
      end
    end else if (cmp_fire) begin
      case (mode)
        ccpu_pkg::MODE_CSET: pin_r <= 1'b1; // [R11]
        ccpu_pkg::MODE_CCLR: pin_r <= 1'b0; // [R11]
        default:             pin_r <= pin_r; // [R14]
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unit_pin_out_r <= 1'b0;
      unit_pin_oe_r  <= 1'b0;
    end else begin
      unit_pin_out_r <= pin_r;
      unit_pin_oe_r  <= is_pwm(mode) || mode == ccpu_pkg::MODE_CSET || mode == ccpu_pkg::MODE_CCLR;
    end
  end

  // ------------------------------------------------------------
  // Interrupt flag
  // ------------------------------------------------------------
  assign flag_clr = wr_at(bus, ccpu_pkg::OFS_STAT) && bus.wdata[ccpu_pkg::STAT_FLAG_BIT];

  // Set wins over a same-cycle clear; spurious edges on mode change land here too
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unit_irq_flag_r <= 1'b0;
    end else if (cap_evt || cmp_fire) begin
      unit_irq_flag_r <= 1'b1; // [R4] [R7] [R12]
    end else if (flag_clr) begin
      unit_irq_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_out_r <= 1'b0;
    end else begin
      irq_out_r <= unit_irq_flag_r && ie_r;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  cap_load_a: assert property (cap_evt |=> {cvh_r, cvl_r} == $past(first_timer_count)) // [R1]
    else $error("capture did not load timer count");
  cap_rise_a: assert property (mode == ccpu_pkg::MODE_CAPR && fall |-> !cap_evt) // [R2]
    else $error("rising capture fired on falling edge");
  cap_code_a: assert property (mode == ccpu_pkg::MODE_CAP4 && rise && psc_r[1:0] == 2'h3 // [R3]
                               |=> unit_irq_flag_r)
    else $error("fourth edge capture missed");
  flag_hold_a: assert property (unit_irq_flag_r && !flag_clr |=> unit_irq_flag_r) // [R4]
    else $error("irq flag dropped without software clear");
  psc_clear_a: assert property (!is_cap(mode) ##1 !is_cap(mode) |-> psc_r == 4'h0) // [R8]
    else $error("capture prescaler not cleared");
  cmp_set_a: assert property (cmp_fire && mode == ccpu_pkg::MODE_CSET && !bus.wr // [R11]
                              |=> pin_r ##1 unit_pin_out_r)
    else $error("compare set did not raise pin");
  cmp_flag_a: assert property (cmp_fire |=> unit_irq_flag_r) // [R12]
    else $error("compare match did not set flag");
  zero_ctrl_a: assert property (wr_at(bus, ccpu_pkg::OFS_CTRL) && bus.wdata == 8'h00 // [R13]
                                |=> !pin_r)
    else $error("zero control did not clear pin latch");
  swi_pin_a: assert property (mode == ccpu_pkg::MODE_CSWI && !bus.wr |=> $stable(pin_r)) // [R14]
    else $error("software interrupt mode moved pin");
  sev_cancel_a: assert property (first_timer_clear_r && !cmp_match |=> !first_timer_clear_r) // [R18]
    else $error("timer reset not cancelled");
  pwm_start_a: assert property (is_pwm(mode) && boundary && {cvl_r, dc} != 10'h000 && !bus.wr // [R19]
                                ##1 !bus.wr |-> t2_r == 8'h00 ##1 pin_r)
    else $error("pwm period start wrong");
  pwm_low_a: assert property (is_pwm(mode) && !boundary && tbase == {cvh_r, lat2_r} && !bus.wr // [R25]
                              |=> !pin_r)
    else $error("pwm duty match did not clear pin");
  cvh_ro_a: assert property (is_pwm(mode) && !boundary && !cap_evt |=> $stable(cvh_r)) // [R23]
    else $error("high value changed in pwm mode");

  cap_c: cover property (cap_evt ##[1:20] cap_evt);
  sev_c: cover property (first_timer_clear_r ##[1:10] first_timer_tick);
  cmp_c: cover property (cmp_fire && mode == ccpu_pkg::MODE_CCLR ##2 !unit_pin_out_r);
  pwm_c: cover property (is_pwm(mode) && boundary ##[1:200] !pin_r);

endmodule

// ---- sim/ccpu_pin_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// External source and load on the unit pin
// ----------------------------------------
module ccpu_pin_model (
  // Source side, set by the bench
  input  wire logic src_lvl,
  // Unit drive
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // Resolved wire level
  output logic      pin_level
);
  // The source stays high impedance while the unit drives, so the wire follows the unit
  assign pin_level = pin_oe ? pin_out : src_lvl;
endmodule

// ---- sim/tb_ccpu_top.sv ----
`timescale 1ns/100ps
module tb_ccpu_top;
  logic                ref_clk   = 1'h0;
  logic                srst      = 1'h1;
  ccpu_pkg::ccpu_bus_t bus       = '0;
  logic [15:0]         ft_cnt    = 16'h0000;
  logic                ft_tick   = 1'h0;
  logic                adc_en    = 1'h0;
  logic                src_lvl   = 1'h0;
  logic [7:0]          rdata_r;
  logic                clr, adc_st, pin_out, pin_oe, flag, irq, pin_lvl;
  int                  bad_count = 0;
  int                  checked   = 0;

  always #4 ref_clk = ~ref_clk;

  // Timer runs on the unit clock; asynchronous counting is never modelled
  always @(posedge ref_clk)
    if (ft_tick) ft_cnt <= clr ? 16'h0000 : ft_cnt + 16'h0001;

  ccpu_top i_ccpu_top (.ref_clk(ref_clk), .srst(srst), .bus(bus), .rdata_r(rdata_r),
    .first_timer_count(ft_cnt), .first_timer_tick(ft_tick), .adc_enable(adc_en),
    .first_timer_clear_r(clr), .adc_start_r(adc_st), .unit_pin_in(pin_lvl),
    .unit_pin_out_r(pin_out), .unit_pin_oe_r(pin_oe), .unit_irq_flag_r(flag), .irq_out_r(irq));

  ccpu_pin_model i_ccpu_pin_model (.src_lvl(src_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_lvl));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic end_sim();
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge ref_clk);
    bus.wr <= 1'h0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge ref_clk);
    bus.rd <= 1'h0;
    #1;
    chk({8'h00, rdata_r}, {8'h00, exp});
  endtask

  task automatic pin(input logic v);
    @(posedge ref_clk);
    src_lvl <= v;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic edges(input int n);
    repeat (n) begin
      pin(1'h1);
      pin(1'h0);
    end
    #1;
  endtask

  task automatic setc(input logic [15:0] v);
    @(posedge ref_clk);
    ft_cnt <= v;
  endtask

  // Width of one high pulse and one full period, in clocks
  task automatic pw(output int h, output int p);
    int i;
    logic prev;
    prev = 1'h1;
    for (i = 0; i < 400 && !(pin_out === 1'h1 && prev === 1'h0); i++) begin
      prev = pin_out;
      cyc(1);
    end
    for (h = 0; h < 400 && pin_out === 1'h1; h++) cyc(1);
    for (p = h; p < 400 && pin_out === 1'h0; p++) cyc(1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(ccpu_pkg::OFS_CTRL, 8'h00);
    rd(ccpu_pkg::OFS_PER, 8'hFF);
    wr(ccpu_pkg::OFS_CTRL, 8'hF5);
    rd(ccpu_pkg::OFS_CTRL, 8'h35);
    rd(3'h7, 8'h00);
    wr(ccpu_pkg::OFS_CTRL, 8'h00);
  endtask

  task automatic t_capture();
    wr(ccpu_pkg::OFS_STAT, 8'h03);
    setc(16'hA55A);
    wr(ccpu_pkg::OFS_CTRL, 8'h05);
    edges(0);
    pin(1'h1);
    cyc(2);
    rd(ccpu_pkg::OFS_CVL, 8'h5A);
    rd(ccpu_pkg::OFS_CVH, 8'hA5);
    chk1(irq, 1'h1);
    setc(16'h1234);
    pin(1'h0);
    cyc(2);
    rd(ccpu_pkg::OFS_CVL, 8'h5A);
    pin(1'h1);
    cyc(2);
    rd(ccpu_pkg::OFS_CVL, 8'h34);
    rd(ccpu_pkg::OFS_CVH, 8'h12);
    chk1(flag, 1'h1);
    wr(ccpu_pkg::OFS_CTRL, 8'h04);
    setc(16'h0777);
    pin(1'h0);
    cyc(2);
    rd(ccpu_pkg::OFS_CVL, 8'h77);
    wr(ccpu_pkg::OFS_STAT, 8'h01);
    rd(ccpu_pkg::OFS_STAT, 8'h00);
  endtask

  task automatic t_prescale();
    wr(ccpu_pkg::OFS_CTRL, 8'h06);
    edges(2);
    // Turning off must drop the four edges already counted, two of them left from t_capture
    wr(ccpu_pkg::OFS_CTRL, 8'h00);
    wr(ccpu_pkg::OFS_CTRL, 8'h06);
    wr(ccpu_pkg::OFS_STAT, 8'h01);
    edges(3);
    chk1(flag, 1'h0);
    setc(16'h0BEE);
    edges(1);
    chk1(flag, 1'h1);
    rd(ccpu_pkg::OFS_CVL, 8'hEE);
    wr(ccpu_pkg::OFS_CTRL, 8'h00);
    wr(ccpu_pkg::OFS_CTRL, 8'h07);
    wr(ccpu_pkg::OFS_STAT, 8'h01);
    edges(15);
    chk1(flag, 1'h0);
    edges(1);
    chk1(flag, 1'h1);
  endtask

  task automatic t_compare();
    wr(ccpu_pkg::OFS_CTRL, 8'h00);
    wr(ccpu_pkg::OFS_STAT, 8'h01);
    wr(ccpu_pkg::OFS_CVL, 8'h40);
    wr(ccpu_pkg::OFS_CVH, 8'h12);
    setc(16'h0000);
    wr(ccpu_pkg::OFS_CTRL, 8'h08);
    setc(16'h1240);
    cyc(3);
    chk1(pin_out, 1'h1);
    chk1(flag, 1'h1);
    setc(16'h0000);
    wr(ccpu_pkg::OFS_CTRL, 8'h09);
    setc(16'h1240);
    cyc(3);
    chk1(pin_out, 1'h0);
    chk1(pin_oe, 1'h1);
    // Raise the pin again so that the zero write has something to clear
    wr(ccpu_pkg::OFS_CTRL, 8'h08);
    setc(16'h0000);
    setc(16'h1240);
    cyc(3);
    chk1(pin_out, 1'h1);
    wr(ccpu_pkg::OFS_CTRL, 8'h00);
    cyc(2);
    chk1(pin_out, 1'h0);
    wr(ccpu_pkg::OFS_STAT, 8'h01);
    wr(ccpu_pkg::OFS_CTRL, 8'h0A);
    setc(16'h0000);
    setc(16'h1240);
    cyc(3);
    chk1(flag, 1'h1);
    chk1(pin_oe, 1'h0);
  endtask

  task automatic t_special();
    int mx;
    int n;
    mx = 0;
    n = 0;
    wr(ccpu_pkg::OFS_CTRL, 8'h00);
    wr(ccpu_pkg::OFS_CVL, 8'h10);
    wr(ccpu_pkg::OFS_CVH, 8'h00);
    setc(16'h0000);
    adc_en <= 1'h1;
    wr(ccpu_pkg::OFS_CTRL, 8'h0B);
    ft_tick <= 1'h1;
    repeat (90) begin
      cyc(1);
      if (ft_cnt > mx) mx = ft_cnt;
      if (adc_st === 1'h1) n++;
    end
    chk(16'(mx), 16'h0011);
    chk1(n > 3, 1'h1);
    chk1(pin_oe, 1'h0);
    adc_en <= 1'h0;
    n = 0;
    repeat (40) begin
      cyc(1);
      if (adc_st === 1'h1) n++;
    end
    chk(16'(n), 16'h0000);
    ft_tick <= 1'h0;
    setc(16'h0010);
    cyc(3);
    chk1(clr, 1'h1);
    wr(ccpu_pkg::OFS_CVL, 8'h30);
    cyc(3);
    chk1(clr, 1'h0);
    ft_tick <= 1'h1;
    @(posedge ref_clk);
    ft_tick <= 1'h0;
    cyc(1);
    chk(ft_cnt, 16'h0011);
  endtask

  task automatic t_pwm();
    int h;
    int p;
    wr(ccpu_pkg::OFS_CTRL, 8'h00);
    wr(ccpu_pkg::OFS_PER, 8'h03);
    wr(ccpu_pkg::OFS_CVL, 8'h02);
    wr(ccpu_pkg::OFS_CTRL, 8'h2C);
    wr(ccpu_pkg::OFS_T2C, 8'h04);
    pw(h, p);
    chk(16'(h), 16'h000A);
    chk(16'(p), 16'h0010);
    chk1(pin_oe, 1'h1);
    wr(ccpu_pkg::OFS_CVH, 8'hFF);
    rd(ccpu_pkg::OFS_CVH, 8'h02);
    wr(ccpu_pkg::OFS_CVL, 8'h01);
    wr(ccpu_pkg::OFS_CTRL, 8'h1C);
    pw(h, p);
    chk(16'(h), 16'h0005);
    wr(ccpu_pkg::OFS_T2C, 8'h05);
    pw(h, p);
    pw(h, p);
    chk(16'(h), 16'h0014);
    chk(16'(p), 16'h0040);
    wr(ccpu_pkg::OFS_T2C, 8'h06);
    pw(h, p);
    pw(h, p);
    chk(16'(h), 16'h0050);
    chk(16'(p), 16'h0100);
    wr(ccpu_pkg::OFS_CVL, 8'h00);
    wr(ccpu_pkg::OFS_CTRL, 8'h0C);
    // A full period at prescale 16 must pass before the zero duty is loaded
    cyc(300);
    h = 0;
    repeat (130) begin
      cyc(1);
      if (pin_out !== 1'h0) h++;
    end
    chk(16'(h), 16'h0000);
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'h0;
    t_regs();
    t_capture();
    t_prescale();
    t_compare();
    t_special();
    t_pwm();
    end_sim();
  end

  // Whole sequence needs a few thousand clocks; this leaves ample margin
  initial begin
    #(30000 * 8);
    bad_count++;
    end_sim();
  end
endmodule
